// ==== hw/qdie_map.svh ====
/*
 * Holds the address map, field positions, reset values and counts of the quadrature
 * decoder interrupt-enable block.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef QDIE_MAP_SVH
`define QDIE_MAP_SVH

// Register byte offsets
`define QDIE_OFS_ENABLE_SET 12'h304
`define QDIE_OFS_ENABLE_CLR 12'h308
`define QDIE_OFS_EVENT_STAT 12'h30C
`define QDIE_OFS_REPORT_PER 12'h510

// Event bit positions, shared by enable and status registers
`define QDIE_BIT_SAMPLE 0
`define QDIE_BIT_REPORT 1
`define QDIE_BIT_ACCUM_OVERFLOW_EVENT 2
`define QDIE_BIT_DOUBLE 3
`define QDIE_BIT_STOPPED 4
`define QDIE_NUM_EVENTS 5

// Reset values
`define QDIE_RST_ENABLE 5'h00
`define QDIE_RST_STATUS 5'h00
`define QDIE_RST_PERIOD 8'h0A
`define QDIE_RST_WORD 32'h00000000

`endif

// ==== hw/qdie_pkg.sv ====
/*
 * Holds the shared types of the quadrature decoder interrupt-enable block.
 * Assumes the map header supplies event count and widths.
 */
`include "qdie_map.svh"

package qdie_pkg;
    // APB data word and event vector
    typedef logic [31:0] qdie_word_type;
    typedef logic [`QDIE_NUM_EVENTS-1:0] qdie_evt_type;
    // APB slave phase
    typedef enum logic [0:0] {QDIE_IDLE, QDIE_ACCESS} qdie_phase_type;
    // Decoded register selection
    typedef enum logic [2:0] {QDIE_SEL_NONE, QDIE_SEL_SET, QDIE_SEL_CLR, QDIE_SEL_STAT, QDIE_SEL_PER} qdie_sel_type;
endpackage

// ==== hw/qdie_if.sv ====
/*
 * Holds the carriers between the block's own modules: register access and events.
 * Assumes one clock domain; all signals are sampled on clk_sys.
 */
interface qdie_bus_if;
    import qdie_pkg::*;
    logic wrStrobe; // One-cycle committed write
    qdie_sel_type sel; // Decoded register of current transfer
    qdie_word_type wrData; // Write data
    qdie_word_type rdData; // Read data for the decoded register
    modport slave (output wrStrobe, output sel, output wrData, input rdData);
    modport regs (input wrStrobe, input sel, input wrData, output rdData);
endinterface

interface qdie_evt_if;
    import qdie_pkg::*;
    qdie_evt_type evt; // One-cycle event pulses
    logic [7:0] period; // Report period in samples
    modport src (output evt, input period);
    modport dst (input evt, output period);
endinterface

// ==== hw/qdie_apb_slave.sv ====
/*
 * Holds the APB slave: address decode, no wait state, registered answer.
 * Assumes an APB master that holds the request until pready is sampled high.
 */
`include "qdie_map.svh"

module qdie_apb_slave #(
    parameter int ADDR_W = 16 // APB address width
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire qdie_pkg::qdie_word_type pwdata, // APB write data
    output qdie_pkg::qdie_word_type prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    qdie_bus_if.slave bus // Register access
);
    import qdie_pkg::*;

    qdie_phase_type phase_q;
    qdie_sel_type selNow;

    // Address decode of the word-aligned offsets
    function automatic qdie_sel_type decodeAddr(input logic [ADDR_W-1:0] a);
        case (a[11:0])
            `QDIE_OFS_ENABLE_SET: decodeAddr = QDIE_SEL_SET;
            `QDIE_OFS_ENABLE_CLR: decodeAddr = QDIE_SEL_CLR;
            `QDIE_OFS_EVENT_STAT: decodeAddr = QDIE_SEL_STAT;
            `QDIE_OFS_REPORT_PER: decodeAddr = QDIE_SEL_PER;
            default: decodeAddr = QDIE_SEL_NONE;
        endcase
        if (a[ADDR_W-1:12] != '0) begin
            decodeAddr = QDIE_SEL_NONE;
        end
    endfunction

    generate
        if (ADDR_W < 13) begin : g_chk
            $error("qdie_apb_slave: ADDR_W must exceed 12");
        end
    endgenerate

    assign selNow = decodeAddr(paddr);
    assign bus.sel = selNow;
    assign bus.wrData = pwdata;
    assign bus.wrStrobe = ce && psel && penable && pwrite && pready;

    // Phase tracking and registered answer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_q <= QDIE_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `QDIE_RST_WORD;
        end else if (ce) begin
            case (phase_q)
                QDIE_IDLE: begin
                    if (psel && !penable) begin
                        phase_q <= QDIE_ACCESS;
                        pready <= 1'b1;
                        pslverr <= (selNow == QDIE_SEL_NONE);
                        prdata <= pwrite ? `QDIE_RST_WORD : bus.rdData;
                    end
                end
                QDIE_ACCESS: begin
                    phase_q <= QDIE_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    prdata <= `QDIE_RST_WORD;
                end
                default: phase_q <= QDIE_IDLE;
            endcase
        end
    end
endmodule

// ==== hw/qdie_event_gen.sv ====
/*
 * Holds the event generator: counts samples over the report period and raises
 * sample, report, overflow, double and stopped event pulses.
 * Assumes the decoder core gives one-cycle sample, overflow and stop pulses.
 */
`include "qdie_map.svh"

module qdie_event_gen (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic sampleTick, // New sample taken
    input wire logic accNonzero, // Motion accumulator holds nonzero
    input wire logic dblNonzero, // Double-transition accumulator nonzero
    input wire logic accOverflow, // Motion accumulator overflowed
    input wire logic dblOverflow, // Double-transition accumulator overflowed
    input wire logic stoppedPulse, // Decoder has stopped
    qdie_evt_if.src ev // Event pulses out
);
    import qdie_pkg::*;

    logic [7:0] sampleCnt_q;
    logic periodDone;

    // Period reached on this sample; zero period acts as one
    assign periodDone = sampleTick && ((sampleCnt_q + 8'h01) >= ev.period);

    // Samples accumulated since the last period end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sampleCnt_q <= 8'h00;
        end else if (ce && sampleTick) begin
            sampleCnt_q <= periodDone ? 8'h00 : sampleCnt_q + 8'h01;
        end
    end

    // Event pulses
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ev.evt <= `QDIE_RST_STATUS;
        end else if (ce) begin
            ev.evt[`QDIE_BIT_SAMPLE] <= sampleTick;
            ev.evt[`QDIE_BIT_REPORT] <= periodDone && accNonzero;
            ev.evt[`QDIE_BIT_ACCUM_OVERFLOW_EVENT] <= accOverflow || dblOverflow;
            ev.evt[`QDIE_BIT_DOUBLE] <= periodDone && dblNonzero;
            ev.evt[`QDIE_BIT_STOPPED] <= stoppedPulse;
        end
    end

    // Report only after the period with motion present
    reportGate_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ev.evt[`QDIE_BIT_REPORT] && $past(ce)) |-> $past(sampleTick) && $past(accNonzero)
            && ($past(sampleCnt_q) + 8'h01 >= $past(ev.period)))
        else $error("report event without full period and motion");

    // No double event after a sample without a double transition
    doubleGate_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && sampleTick && !dblNonzero) |=> !ev.evt[`QDIE_BIT_DOUBLE])
        else $error("double event without double transition");
endmodule

// ==== hw/qdie_top.sv ====
/*
 * Holds the top of the quadrature decoder interrupt-enable block: shared enable
 * register reached through set and clear addresses, sticky event status, report
 * period, and the interrupt request.
 * Assumes an APB master on clk_sys and a decoder core giving event pulses.
 */
// Local design decision: register access over APB.
// Overview of operation
// - Write one to set-register enables; reads enables
// - Write one to clear-register disables; same readback
// - Five enable bits: sample, report, overflow, double, stopped
// - Report event after period with nonzero motion
// - Double event after period with nonzero doubles
// - Overflow event on either accumulator overflow
`include "qdie_map.svh"

module qdie_top #(
    parameter int ADDR_W = 16 // APB address width
) (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes all state
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire qdie_pkg::qdie_word_type pwdata, // APB write data
    output qdie_pkg::qdie_word_type prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic sampleTick, // New sample taken
    input wire logic accNonzero, // Motion accumulator nonzero
    input wire logic dblNonzero, // Double-transition accumulator nonzero
    input wire logic accOverflow, // Motion accumulator overflow
    input wire logic dblOverflow, // Double-transition accumulator overflow
    input wire logic stoppedPulse, // Decoder stopped
    output logic irq // Interrupt request, level
);
    import qdie_pkg::*;

    qdie_bus_if bus ();
    qdie_evt_if ev ();

    qdie_evt_type enable_q;
    qdie_evt_type enable_d;
    qdie_evt_type status_q;
    qdie_evt_type status_d;
    logic [7:0] period_q;
    qdie_evt_type wrLow;
    logic pendingAny;
    logic setWr;
    logic clrWr;
    logic statClr;
    logic perWr;

    ////////////////////////////////////////////////////////////////////////////
    // Submodules

    // Bus slave
    qdie_apb_slave #(
        .ADDR_W(ADDR_W)
    ) u_apb (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus.slave)
    );

    // Event generator
    qdie_event_gen u_evt (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .sampleTick(sampleTick),
        .accNonzero(accNonzero),
        .dblNonzero(dblNonzero),
        .accOverflow(accOverflow),
        .dblOverflow(dblOverflow),
        .stoppedPulse(stoppedPulse),
        .ev(ev.src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    assign wrLow = bus.wrData[`QDIE_NUM_EVENTS-1:0];
    assign ev.period = period_q;

    // Committed write to one decoded register
    function automatic logic hitWrite(input logic strobe, input qdie_sel_type sel, input qdie_sel_type which);
        hitWrite = strobe && (sel == which);
    endfunction

    // Committed writes per register
    assign setWr = hitWrite(bus.wrStrobe, bus.sel, QDIE_SEL_SET);
    assign clrWr = hitWrite(bus.wrStrobe, bus.sel, QDIE_SEL_CLR);
    assign statClr = hitWrite(bus.wrStrobe, bus.sel, QDIE_SEL_STAT);
    assign perWr = hitWrite(bus.wrStrobe, bus.sel, QDIE_SEL_PER);

    // Refuse address widths the decoder cannot serve
    generate
        if (ADDR_W < 13) begin : g_addrChk
            $error("qdie_top: ADDR_W must exceed 12");
        end
    endgenerate

    // Shared enable: set and clear addresses act on one register
    always_comb begin
        enable_d = enable_q;
        if (setWr) begin
            enable_d = enable_q | wrLow;
        end else if (clrWr) begin
            enable_d = enable_q & ~wrLow;
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (statClr) begin
            status_d = status_q & ~wrLow;
        end
        status_d = status_d | ev.evt;
    end

    // Enable register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            enable_q <= `QDIE_RST_ENABLE;
        end else if (ce) begin
            enable_q <= enable_d;
        end
    end

    // Status register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_q <= `QDIE_RST_STATUS;
        end else if (ce) begin
            status_q <= status_d;
        end
    end

    // Report period register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            period_q <= `QDIE_RST_PERIOD;
        end else if (ce && perWr) begin
            period_q <= bus.wrData[7:0];
        end
    end

    // Read mux; both enable addresses show the same state
    always_comb begin
        bus.rdData = `QDIE_RST_WORD;
        case (bus.sel)
            QDIE_SEL_SET: bus.rdData[`QDIE_NUM_EVENTS-1:0] = enable_q;
            QDIE_SEL_CLR: bus.rdData[`QDIE_NUM_EVENTS-1:0] = enable_q;
            QDIE_SEL_STAT: bus.rdData[`QDIE_NUM_EVENTS-1:0] = status_q;
            QDIE_SEL_PER: bus.rdData[7:0] = period_q;
            default: bus.rdData = `QDIE_RST_WORD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output

    assign pendingAny = |(status_q & enable_q);

    // Level request from any enabled pending event
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= pendingAny;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Set write turns the written enables on
    setEnable_a: assert property (@(posedge clk_sys) disable iff (srst)
        (bus.wrStrobe && bus.sel == QDIE_SEL_SET) |=> ((enable_q & $past(wrLow)) == $past(wrLow)))
        else $error("set write did not enable");

    // Set-address read returns the enable state
    readSet_a: assert property (@(posedge clk_sys) disable iff (srst)
        (psel && !penable && !pwrite && bus.sel == QDIE_SEL_SET && ce)
            |=> (prdata[`QDIE_NUM_EVENTS-1:0] == enable_q) && pready)
        else $error("set read mismatch");

    // Clear write turns the written enables off, others kept
    clearEnable_a: assert property (@(posedge clk_sys) disable iff (srst)
        (bus.wrStrobe && bus.sel == QDIE_SEL_CLR)
            |=> (enable_q == ($past(enable_q) & ~$past(wrLow))))
        else $error("clear write wrong");

    // Clear-address read returns the enable state
    readClr_a: assert property (@(posedge clk_sys) disable iff (srst)
        (psel && !penable && !pwrite && bus.sel == QDIE_SEL_CLR && ce)
            |=> (prdata[`QDIE_NUM_EVENTS-1:0] == enable_q))
        else $error("clear read mismatch");

    // Only five enable bits exist; upper bits read zero
    fiveBits_a: assert property (@(posedge clk_sys) disable iff (srst)
        (pready && !pwrite && bus.sel inside {QDIE_SEL_SET, QDIE_SEL_CLR})
            |-> (prdata[31:`QDIE_NUM_EVENTS] == '0))
        else $error("enable readback has upper bits");

    // Overflow of either accumulator reaches status in two cycles
    overflowFlag_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && (accOverflow || dblOverflow)) ##1 ce |=> status_q[`QDIE_BIT_ACCUM_OVERFLOW_EVENT])
        else $error("overflow not flagged");

    // Request follows enabled pending flags one cycle later
    irqLevel_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce |=> (irq == $past(pendingAny)))
        else $error("irq does not follow pending");

    // Zero writes leave the enable state alone
    zeroWrite_a: assert property (@(posedge clk_sys) disable iff (srst)
        (bus.wrStrobe && wrLow == '0 && bus.sel inside {QDIE_SEL_SET, QDIE_SEL_CLR})
            |=> $stable(enable_q))
        else $error("zero write changed enable");

    // Set write keeps enables already on
    setKeep_a: assert property (@(posedge clk_sys) disable iff (srst)
        setWr
            |=> (enable_q == ($past(enable_q) | $past(wrLow))))
        else $error("set write lost enables");

    // Status bits stay until cleared by a write
    statSticky_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && !statClr)
            |=> ((status_q & $past(status_q)) == $past(status_q)))
        else $error("status bit dropped without clear");

    // An event wins over a clear in the same cycle
    setWins_a: assert property (@(posedge clk_sys) disable iff (srst)
        (statClr && (ev.evt != '0))
            |=> ((status_q & $past(ev.evt)) == $past(ev.evt)))
        else $error("clear beat a new event");

    // Status clear drops only the written bits
    statClear_a: assert property (@(posedge clk_sys) disable iff (srst)
        (statClr && (ev.evt == '0))
            |=> (status_q == ($past(status_q) & ~$past(wrLow))))
        else $error("status clear wrong");

    // Sample event reaches its status bit
    sampleFlag_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && ev.evt[`QDIE_BIT_SAMPLE])
            |=> status_q[`QDIE_BIT_SAMPLE])
        else $error("sample event not flagged");

    // Report event reaches its status bit
    reportFlag_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && ev.evt[`QDIE_BIT_REPORT])
            |=> status_q[`QDIE_BIT_REPORT])
        else $error("report event not flagged");

    // Double event reaches its status bit
    doubleFlag_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && ev.evt[`QDIE_BIT_DOUBLE])
            |=> status_q[`QDIE_BIT_DOUBLE])
        else $error("double event not flagged");

    // Stopped event reaches its status bit
    stopFlag_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && ev.evt[`QDIE_BIT_STOPPED])
            |=> status_q[`QDIE_BIT_STOPPED])
        else $error("stopped event not flagged");

    // Unmapped address answers with an error and zero data
    unmapped_a: assert property (@(posedge clk_sys) disable iff (srst)
        (psel && !penable && ce && bus.sel == QDIE_SEL_NONE)
            |=> (pslverr && pready && (prdata == '0)))
        else $error("unmapped access not refused");

    // Ready stands for one cycle
    readyPulse_a: assert property (@(posedge clk_sys) disable iff (srst)
        (pready && ce)
            |=> !pready)
        else $error("ready held too long");

    // Period write lands whole
    perWrite_a: assert property (@(posedge clk_sys) disable iff (srst)
        perWr
            |=> (period_q == $past(bus.wrData[7:0])))
        else $error("period write lost");

    // No request without an enabled pending flag
    irqQuiet_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ce && ((status_q & enable_q) == '0))
            |=> !irq)
        else $error("irq without enabled flag");

    // Frozen while clock enable is low
    freeze_a: assert property (@(posedge clk_sys) disable iff (srst)
        !ce |=> $stable(enable_q) && $stable(status_q) && $stable(irq))
        else $error("state moved with ce low");
endmodule

// ==== test/qdie_core_model.sv ====
/*
 * Holds a model of the decoder core that feeds event pulses to the block.
 * Assumes one clock; a pulse is raised after one edge and dropped after the next.
 */
module qdie_core_model (
    input wire logic clk_sys, // System clock
    output logic sampleTick, // New sample pulse
    output logic accNonzero, // Motion accumulator nonzero
    output logic dblNonzero, // Double accumulator nonzero
    output logic accOverflow, // Motion overflow pulse
    output logic dblOverflow, // Double overflow pulse
    output logic stoppedPulse // Stopped pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet core at time zero
    initial begin
        {sampleTick, accNonzero, dblNonzero, accOverflow, dblOverflow, stoppedPulse} = 6'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One event: kind 0 sample, 1 motion overflow, 2 double overflow, 3 stopped
    task automatic fire(input int kind, input logic acc, input logic dbl);
        @(posedge clk_sys);
        accNonzero <= acc;
        dblNonzero <= dbl;
        sampleTick <= (kind == 0);
        accOverflow <= (kind == 1);
        dblOverflow <= (kind == 2);
        stoppedPulse <= (kind == 3);
        @(posedge clk_sys);
        {sampleTick, accOverflow, dblOverflow, stoppedPulse} <= 4'h0;
        // Let the status bit settle before anyone reads it
        repeat (3) @(posedge clk_sys);
    endtask
endmodule

// ==== test/qdie_testbench.sv ====
/*
 * Holds the self-checking bench: APB read and write tasks and event sequences.
 * Assumes the core model above and the register map header.
 */
`include "qdie_map.svh"

module testbench;
    import qdie_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys, srst, ce, psel, penable, pwrite, pready, pslverr, irq, err;
    logic sampleTick, accNonzero, dblNonzero, accOverflow, dblOverflow, stoppedPulse;
    logic [15:0] paddr;
    qdie_word_type pwdata, prdata, rd;
    int errorCnt, comparisons, n;
    logic [4:0] expTab [6] = '{5'h01, 5'h03, 5'h09, 5'h04, 5'h04, 5'h10};
    int kindTab [6] = '{0, 0, 0, 1, 2, 3};

    qdie_top #(.ADDR_W(16)) qdie_top_inst (.clk_sys(clk_sys), .srst(srst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sampleTick(sampleTick), .accNonzero(accNonzero),
        .dblNonzero(dblNonzero), .accOverflow(accOverflow), .dblOverflow(dblOverflow),
        .stoppedPulse(stoppedPulse), .irq(irq));

    qdie_core_model qdie_core_model_inst (.clk_sys(clk_sys), .sampleTick(sampleTick),
        .accNonzero(accNonzero), .dblNonzero(dblNonzero), .accOverflow(accOverflow),
        .dblOverflow(dblOverflow), .stoppedPulse(stoppedPulse));

    ////////////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Counts a comparison and reports a difference
    task automatic chk(input qdie_word_type seen, input qdie_word_type exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [15:0] addr, input qdie_word_type wd);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Read and compare
    task automatic rchk(input logic [15:0] addr, input qdie_word_type exp);
        apb(1'h0, addr, 32'h00000000);
        chk(rd, exp);
    endtask

    // Wait for the registered interrupt, then compare it
    task automatic ichk(input logic exp);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        errorCnt++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {srst, ce, psel, penable, pwrite} = 5'h19;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        errorCnt = 0;
        comparisons = 0;
        repeat (16) @(posedge clk_sys);
        srst <= 1'h0;
        // Reset state
        rchk(`QDIE_OFS_ENABLE_SET, 32'h00000000);
        rchk(`QDIE_OFS_ENABLE_CLR, 32'h00000000);
        rchk(`QDIE_OFS_REPORT_PER, 32'h0000000A);
        chk({31'h0, irq}, 32'h00000000);
        // Set enables one bit at a time, both addresses read the same mask
        for (n = 0; n < 5; n++) begin
            apb(1'h1, `QDIE_OFS_ENABLE_SET, 32'h00000001 << n);
            rchk(`QDIE_OFS_ENABLE_SET, (32'h00000002 << n) - 32'h1);
            rchk(`QDIE_OFS_ENABLE_CLR, (32'h00000002 << n) - 32'h1);
        end
        // Zero writes leave the mask alone
        apb(1'h1, `QDIE_OFS_ENABLE_SET, 32'h00000000);
        apb(1'h1, `QDIE_OFS_ENABLE_CLR, 32'h00000000);
        rchk(`QDIE_OFS_ENABLE_SET, 32'h0000001F);
        // Clear enables one bit at a time
        for (n = 0; n < 5; n++) begin
            apb(1'h1, `QDIE_OFS_ENABLE_CLR, 32'h00000001 << n);
            rchk(`QDIE_OFS_ENABLE_CLR, 32'h0000001E << n & 32'h0000001F);
        end
        // Unmapped address: error, zero data, no effect
        apb(1'h1, 16'h0400, 32'h0000001F);
        chk({31'h0, err}, 32'h00000001);
        apb(1'h0, 16'h0400, 32'h00000000);
        chk(rd, 32'h00000000);
        rchk(`QDIE_OFS_ENABLE_SET, 32'h00000000);
        // Each event kind sets its status bit, both overflow kinds the same bit, period one sample
        apb(1'h1, `QDIE_OFS_REPORT_PER, 32'h00000001);
        for (n = 0; n < 6; n++) begin
            qdie_core_model_inst.fire(kindTab[n], n == 1, n == 2);
            rchk(`QDIE_OFS_EVENT_STAT, {27'h0, expTab[n]});
            apb(1'h1, `QDIE_OFS_EVENT_STAT, 32'h0000001F);
            rchk(`QDIE_OFS_EVENT_STAT, 32'h00000000);
        end
        // Period of two: the first sample completes nothing
        apb(1'h1, `QDIE_OFS_REPORT_PER, 32'h00000002);
        qdie_core_model_inst.fire(0, 1'h1, 1'h1);
        rchk(`QDIE_OFS_EVENT_STAT, 32'h00000001);
        qdie_core_model_inst.fire(0, 1'h1, 1'h1);
        rchk(`QDIE_OFS_EVENT_STAT, 32'h0000000B);
        apb(1'h1, `QDIE_OFS_EVENT_STAT, 32'h0000001F);
        // Interrupt follows only enabled flags
        apb(1'h1, `QDIE_OFS_REPORT_PER, 32'h00000001);
        apb(1'h1, `QDIE_OFS_ENABLE_SET, 32'h00000002);
        qdie_core_model_inst.fire(0, 1'h0, 1'h0);
        ichk(1'h0);
        qdie_core_model_inst.fire(0, 1'h1, 1'h0);
        ichk(1'h1);
        apb(1'h1, `QDIE_OFS_ENABLE_CLR, 32'h00000002);
        ichk(1'h0);
        apb(1'h1, `QDIE_OFS_ENABLE_SET, 32'h00000002);
        ichk(1'h1);
        apb(1'h1, `QDIE_OFS_EVENT_STAT, 32'h0000001F);
        ichk(1'h0);
        // Frozen with clock enable low, then a mid-run reset
        ce <= 1'h0;
        repeat (4) @(posedge clk_sys);
        ce <= 1'h1;
        rchk(`QDIE_OFS_ENABLE_SET, 32'h00000002);
        srst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'h0;
        rchk(`QDIE_OFS_ENABLE_CLR, 32'h00000000);
        rchk(`QDIE_OFS_REPORT_PER, 32'h0000000A);
        chk({31'h0, irq}, 32'h00000000);
        tally_and_finish();
    end
endmodule
